// ### pll_status_readback_bench.sv
`include "psr_defines.svh"
module pll_status_readback_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, cyc, stb, we, ack, err, thr, irq, e;
    logic [7:0] adr;
    logic [31:0] wd, rd, q;
    logic [6:0] lv;
    logic [3:0] sel;
    logic [3:0] lanes = 4'hF;
    int n_fail = 0;
    int compares = 0;
    psr_top dut (.core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
        .wb_err_o(err), .cal_done_i(lv[6]), .holdover_active_i(lv[5]),
        .ref_in_secondary_sel_i(lv[4]), .vco_above_thr_i(lv[3]),
        .ref_in_secondary_above_thr_i(lv[2]), .ref_in_primary_above_thr_i(lv[1]),
        .lock_detect_i(lv[0]), .thr_sel_o(thr), .irq_o(irq));
    // ----
    // bus and compare helpers
    // ----
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, lanes};
        do @(posedge clk); while (!(ack || err));
        q = rd;
        e = err;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, ex, q);
    endtask
    task automatic s_reset();
        rdc(`PSR_OFS_STATUS, 32'h0, "status reset");
        rdc(`PSR_OFS_EVT_STAT, 32'h0, "event reset");
        rdc(`PSR_OFS_EVT_MASK, 32'h0, "mask reset");
        chk("irq reset", 32'h0, {31'h0, irq});
        chk("thr reset", 32'h0, {31'h0, thr});
    endtask
    task automatic s_lane();
        bus(1'b1, `PSR_OFS_EVT_MASK, 32'h7F);
        rdc(`PSR_OFS_EVT_MASK, 32'h7F, "mask");
        chk("irq pending", 32'h1, {31'h0, irq});
        lanes = 4'hE;
        bus(1'b1, `PSR_OFS_EVT_MASK, 32'h00);
        lanes = 4'hF;
        rdc(`PSR_OFS_EVT_MASK, 32'h7F, "mask lane off");
        bus(1'b1, `PSR_OFS_EVT_MASK, 32'h00);
        rdc(`PSR_OFS_EVT_MASK, 32'h00, "mask cleared");
    endtask
    task automatic s_status();
        for (int i = 0; i < 8; i++) begin
            lv <= (i < 7) ? 7'(1 << i) : 7'h7F;
            repeat (3) @(posedge clk);
            rdc(`PSR_OFS_STATUS, (i < 7) ? 32'(1 << i) : 32'h7F, "status");
        end
    endtask
    task automatic s_ignore();
        lv <= 7'h55;
        repeat (3) @(posedge clk);
        bus(1'b1, `PSR_OFS_STATUS, 32'hFF);
        rdc(`PSR_OFS_STATUS, 32'h55, "status after write");
        rdc(`PSR_OFS_STATUS, 32'h55, "status reread");
    endtask
    task automatic s_cfg_err();
        bus(1'b1, `PSR_OFS_THR_CFG, 32'h40);
        chk("thr_sel", 32'h1, {31'h0, thr});
        rdc(`PSR_OFS_THR_CFG, 32'h40, "thr cfg");
        bus(1'b0, 8'h10, 32'h0);
        chk("err", 32'h1, {31'h0, e});
    endtask
    task automatic s_irq();
        bus(1'b1, `PSR_OFS_EVT_STAT, 32'h7F);
        bus(1'b1, `PSR_OFS_EVT_MASK, 32'h01);
        chk("irq idle", 32'h0, {31'h0, irq});
        lv <= lv ^ 7'h01;
        repeat (3) @(posedge clk);
        chk("irq set", 32'h1, {31'h0, irq});
        rdc(`PSR_OFS_EVT_STAT, 32'h01, "event");
        bus(1'b1, `PSR_OFS_EVT_STAT, 32'h01);
        bus(1'b1, `PSR_OFS_EVT_MASK, 32'h00);
        lv <= lv ^ 7'h01;
        repeat (3) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdc(`PSR_OFS_EVT_STAT, 32'h01, "masked event");
    endtask
    task automatic tally_and_finish();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        {cyc, stb, we, adr, wd, lv, sel} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        s_reset();
        s_status();
        s_ignore();
        s_cfg_err();
        s_lane();
        s_irq();
        tally_and_finish();
    end
endmodule

// ### psr_chk.sv
`include "psr_defines.svh"
module psr_chk (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic cal_done_i,
    input wire logic holdover_active_i,
    input wire logic ref_in_secondary_sel_i,
    input wire logic vco_above_thr_i,
    input wire logic ref_in_secondary_above_thr_i,
    input wire logic ref_in_primary_above_thr_i,
    input wire logic lock_detect_i,
    input wire logic thr_sel_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] lv;
    logic map;
    assign lv = {cal_done_i, holdover_active_i, ref_in_secondary_sel_i, vco_above_thr_i,
        ref_in_secondary_above_thr_i, ref_in_primary_above_thr_i, lock_detect_i};
    assign map = wb_adr_i inside {`PSR_OFS_STATUS, `PSR_OFS_EVT_STAT, `PSR_OFS_EVT_MASK,
        `PSR_OFS_THR_CFG};
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack");
    resp_excl_a: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("idle data");
    err_unmap_a: assert property (wb_err_o |-> !$past(map)) else $error("err on mapped");
    ack_map_a: assert property (wb_ack_o |-> $past(map)) else $error("ack on unmapped");
    status_map_a: assert property (
        wb_ack_o && $past(wb_adr_i == `PSR_OFS_STATUS && !wb_we_i) && lv == $past(lv)
        && lv == $past(lv, 2) && lv == $past(lv, 3) |-> wb_dat_o == {25'h0, lv})
        else $error("status word");
    thr_cause_a: assert property ($changed(thr_sel_o) |-> wb_ack_o
        && $past(wb_we_i && wb_adr_i == `PSR_OFS_THR_CFG)) else $error("thr change");
    cover property (wb_err_o);
    cover property (wb_ack_o && $past(wb_we_i));
    cover property ($rose(irq_o));
endmodule
bind psr_top psr_chk u_chk (.core_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .cal_done_i, .holdover_active_i, .ref_in_secondary_sel_i,
    .vco_above_thr_i, .ref_in_secondary_above_thr_i, .ref_in_primary_above_thr_i,
    .lock_detect_i, .thr_sel_o, .irq_o);

// ### psr_defines.svh
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define PSR_OFS_STATUS 8'h7C
`define PSR_OFS_EVT_STAT 8'h80
`define PSR_OFS_EVT_MASK 8'h84
`define PSR_OFS_THR_CFG 8'h68

// ------------------------------------------------------------
// status and threshold config field positions
// ------------------------------------------------------------
`define PSR_BIT_LOCK 0
`define PSR_BIT_PRI_FREQ 1
`define PSR_BIT_SEC_FREQ 2
`define PSR_BIT_VCO_FREQ 3
`define PSR_BIT_SEC_SEL 4
`define PSR_BIT_HOLD_ACT 5
`define PSR_BIT_CAL_DONE 6
`define PSR_BIT_THR_SEL 6

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PSR_RST_STATUS 8'h00
`define PSR_RST_MASK 8'h00
`define PSR_RST_CFG 8'h00
`define PSR_RST_THR_SEL 1'b0

`endif

// ### psr_edge_detect.sv
module psr_edge_detect #(
    parameter int WIDTH = 7
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] change_o
);
    logic [WIDTH-1:0] level_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("edge detect needs at least one bit");
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            level_q <= '0;
        end else begin
            level_q <= level_i;
        end
    end

    assign level_o = level_q;
    assign change_o = level_q ^ level_i;
endmodule

// ### psr_pkg.sv
package psr_pkg;
    typedef enum logic [1:0] {
        PSR_IDLE,
        PSR_ACK
    } psr_bus_state_t;
    typedef logic [7:0] psr_byte_t;
endpackage

// ### psr_top.sv
`include "psr_defines.svh"
module psr_top (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic cal_done_i,
    input wire logic holdover_active_i,
    input wire logic ref_in_secondary_sel_i,
    input wire logic vco_above_thr_i,
    input wire logic ref_in_secondary_above_thr_i,
    input wire logic ref_in_primary_above_thr_i,
    input wire logic lock_detect_i,
    output logic thr_sel_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    localparam int STAT_W = 7;
    localparam int REG_W = 8;

    // status byte is the captured vector plus one spare top bit
    if (STAT_W + 1 != REG_W) begin : g_bad_width
        $error("status vector must be one bit narrower than a register");
    end

    if ((`PSR_BIT_LOCK >= STAT_W) ||
        (`PSR_BIT_PRI_FREQ >= STAT_W) ||
        (`PSR_BIT_SEC_FREQ >= STAT_W) ||
        (`PSR_BIT_VCO_FREQ >= STAT_W) ||
        (`PSR_BIT_SEC_SEL >= STAT_W) ||
        (`PSR_BIT_HOLD_ACT >= STAT_W) ||
        (`PSR_BIT_CAL_DONE >= STAT_W)) begin : g_bad_field
        $error("status field position outside the status vector");
    end

    if (`PSR_BIT_THR_SEL >= REG_W) begin : g_bad_thr
        $error("threshold select bit outside the config byte");
    end

    // word-aligned offsets keep the decode free of lane steering
    if ((`PSR_OFS_STATUS % 4 != 0) ||
        (`PSR_OFS_EVT_STAT % 4 != 0) ||
        (`PSR_OFS_EVT_MASK % 4 != 0) ||
        (`PSR_OFS_THR_CFG % 4 != 0)) begin : g_bad_align
        $error("register offset not word aligned");
    end

    if ((`PSR_OFS_STATUS == `PSR_OFS_EVT_STAT) ||
        (`PSR_OFS_STATUS == `PSR_OFS_EVT_MASK) ||
        (`PSR_OFS_STATUS == `PSR_OFS_THR_CFG) ||
        (`PSR_OFS_EVT_STAT == `PSR_OFS_EVT_MASK) ||
        (`PSR_OFS_EVT_STAT == `PSR_OFS_THR_CFG) ||
        (`PSR_OFS_EVT_MASK == `PSR_OFS_THR_CFG)) begin : g_bad_map
        $error("two registers share one offset");
    end

    // ------------------------------------------------------------
    // status capture
    // ------------------------------------------------------------
    logic [STAT_W-1:0] raw;
    logic [STAT_W-1:0] stat_lvl;
    logic [STAT_W-1:0] stat_chg;
    psr_pkg::psr_byte_t status_w;

    always_comb begin
        raw = '0;
        raw[`PSR_BIT_CAL_DONE] = cal_done_i;
        raw[`PSR_BIT_HOLD_ACT] = holdover_active_i;
        raw[`PSR_BIT_SEC_SEL] = ref_in_secondary_sel_i;
        raw[`PSR_BIT_VCO_FREQ] = vco_above_thr_i;
        raw[`PSR_BIT_SEC_FREQ] = ref_in_secondary_above_thr_i;
        raw[`PSR_BIT_PRI_FREQ] = ref_in_primary_above_thr_i;
        raw[`PSR_BIT_LOCK] = lock_detect_i;
    end

    psr_edge_detect #(
        .WIDTH(STAT_W)
    ) u_edge (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .level_i(raw),
        .level_o(stat_lvl),
        .change_o(stat_chg)
    );

    // bit 7 has no source and always reads 0
    assign status_w = {1'b0, stat_lvl};

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic req;
    logic hit_status;
    logic hit_evt;
    logic hit_mask;
    logic hit_cfg;
    logic wr_lane0;
    psr_pkg::psr_bus_state_t state_q;
    psr_pkg::psr_bus_state_t state_d;

    assign req = wb_cyc_i && wb_stb_i && (state_q == psr_pkg::PSR_IDLE);
    assign hit_status = wb_adr_i == `PSR_OFS_STATUS;
    assign hit_evt = wb_adr_i == `PSR_OFS_EVT_STAT;
    assign hit_mask = wb_adr_i == `PSR_OFS_EVT_MASK;
    assign hit_cfg = wb_adr_i == `PSR_OFS_THR_CFG;
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

    // one answer per request; a request still held after ack is taken again the cycle after
    always_comb begin
        state_d = state_q;
        case (state_q)
            psr_pkg::PSR_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    state_d = psr_pkg::PSR_ACK;
                end
            end
            psr_pkg::PSR_ACK: begin
                state_d = psr_pkg::PSR_IDLE;
            end
            default: begin
                state_d = psr_pkg::PSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= psr_pkg::PSR_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------
    logic wr_mask;
    logic wr_cfg;
    logic wr_evt;
    logic map_hit;

    // no strobe for the status offset: writes there only get an ack
    assign wr_mask = wr_lane0 && hit_mask;
    assign wr_cfg = wr_lane0 && hit_cfg;
    assign wr_evt = wr_lane0 && hit_evt;
    assign map_hit = hit_status || hit_evt || hit_mask || hit_cfg;

    // ------------------------------------------------------------
    // event mask
    // ------------------------------------------------------------
    logic [7:0] mask_q;
    logic [7:0] mask_d;

    // bit 7 has no event behind it and stays 0
    always_comb begin
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = {1'b0, wb_dat_i[6:0]};
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_q <= `PSR_RST_MASK;
        end else begin
            mask_q <= mask_d;
        end
    end

    // ------------------------------------------------------------
    // threshold select
    // ------------------------------------------------------------
    logic thr_sel_q;
    logic thr_sel_d;

    always_comb begin
        thr_sel_d = thr_sel_q;
        if (wr_cfg) begin
            thr_sel_d = wb_dat_i[`PSR_BIT_THR_SEL];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            thr_sel_q <= `PSR_RST_THR_SEL;
        end else begin
            thr_sel_q <= thr_sel_d;
        end
    end

    assign thr_sel_o = thr_sel_q;

    // ------------------------------------------------------------
    // event status
    // ------------------------------------------------------------
    logic [7:0] evt_q;
    logic [7:0] evt_d;
    logic [7:0] evt_clr;
    logic [7:0] evt_set;

    assign evt_clr = wr_evt ? wb_dat_i[7:0] : 8'h00;
    assign evt_set = {1'b0, stat_chg};

    // per bit: set wins over a write-one-clear in the same cycle
    for (genvar b = 0; b < REG_W; b++) begin : g_evt
        assign evt_d[b] = (evt_q[b] & ~evt_clr[b]) | evt_set[b];
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            evt_q <= `PSR_RST_STATUS;
        end else begin
            evt_q <= evt_d;
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    logic [7:0] pend_d;
    logic irq_d;

    assign pend_d = evt_d & mask_q;
    assign irq_d = |pend_d;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    psr_pkg::psr_byte_t rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (hit_status) begin
            rd_byte = status_w;
        end else if (hit_evt) begin
            rd_byte = evt_q;
        end else if (hit_mask) begin
            rd_byte = mask_q;
        end else if (hit_cfg) begin
            rd_byte = {1'b0, thr_sel_q, 6'h00};
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    logic ack_d;
    logic err_d;
    logic [31:0] rd_data_d;

    // status writes fall through with ack and no effect
    always_comb begin
        ack_d = 1'b0;
        err_d = 1'b0;
        rd_data_d = 32'h0000_0000;
        if (req) begin
            ack_d = map_hit;
            err_d = !map_hit;
            if (!wb_we_i) begin
                rd_data_d = {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= ack_d;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_err_o <= 1'b0;
        end else begin
            wb_err_o <= err_d;
        end
    end

    // data reads zero outside the answer cycle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= rd_data_d;
        end
    end
endmodule
